// file: wpn_pkg.sv
// constants shared by the write-protect and non-volatile store command block
package wpn_pkg;
	// command codes
	localparam logic [7:0] WPN_CMD_OPERATION = 8'h01;
	localparam logic [7:0] WPN_CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] WPN_CMD_WRITE_LOCKOUT = 8'h10;
	localparam logic [7:0] WPN_CMD_STORE_ALL = 8'h11;
	localparam logic [7:0] WPN_CMD_RESTORE_ALL = 8'h12;
	localparam logic [7:0] WPN_CMD_STORE_ONE = 8'h13;
	localparam logic [7:0] WPN_CMD_RESTORE_ONE = 8'h14;
	// lock bit positions in write_lockout_control
	localparam int WPN_LOCK_ALL_BUT_ONOFF = 5;
	localparam int WPN_LOCK_ALL_BUT_OP = 6;
	localparam int WPN_LOCK_ALL_BUT_WP = 7;
	localparam logic [7:0] WPN_LOCK_RESET = 8'h00;
	localparam logic [7:0] WPN_LOCK_MASK = 8'he0;
	// working register set: one byte per command code
	localparam int WPN_NREG = 256;
	// store-all duration
	localparam int WPN_STORE_MS = 50;
	localparam int WPN_CLK_HZ = 40000000;
	localparam int WPN_STORE_CYC = WPN_STORE_MS * (WPN_CLK_HZ / 1000);
	// counter holds the store-all count; restore-all walks one entry per cycle on idx, not this counter
	localparam int WPN_CNT_W = 22;
endpackage

// file: wpn_nvm.sv
// non-volatile copy of the working register set with a timed store-all
`timescale 1ns/10ps
module wpn_nvm
	import wpn_pkg::*;
#(
	parameter int STORE_CYC = WPN_STORE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data,
	input wire logic hold_start,
	output logic hold_busy
);
	// storage array, kept across resets as the non-volatile part would be
	logic [7:0] mem [WPN_NREG];
	// programming time counter
	logic [WPN_CNT_W-1:0] hold_cnt;

	// writes land at once; busy models the long programming time
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// combinational read keeps the restore walk one entry per cycle
	assign rd_data = mem[rd_addr];

	// busy timer for the bulk store
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= '0;
			hold_busy <= 1'b0;
		end else if (hold_start) begin
			hold_cnt <= WPN_CNT_W'(STORE_CYC - 1);
			hold_busy <= 1'b1;
		end else if (hold_cnt != '0) begin
			hold_cnt <= hold_cnt - 1'b1;
		end else begin
			hold_busy <= 1'b0;
		end
	end
endmodule

// file: wpn_pmbus_cmd.sv
// command interpreter for write lockout and non-volatile store / restore
// Notes on behaviour
// - bit5 set: only lockout, operation, on/off writes
// - bit6 set: only lockout and operation writes
// - bit7 set: only the lockout write passes
// - clear lock bits add no restriction
// - store-all copies every setting, about 50 ms
// - restore-all reloads every working-set entry from memory; the lockout register keeps its value
// - store-one copies only the named command code
// - store-all, restore-all, store-one are 11, 12, 13
// - restore-one reloads only the named code
`timescale 1ns/10ps
module wpn_pmbus_cmd
	import wpn_pkg::*;
#(
	parameter int STORE_CYC = WPN_STORE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic cmd_has_data,
	input wire logic [7:0] cmd_data,
	input wire logic [7:0] rd_code,
	output logic [7:0] rd_data,
	output logic [7:0] write_lockout_control,
	output logic cmd_busy,
	output logic comm_fault
);
	// one-hot sequencer
	typedef enum logic [3:0] {
		WPN_IDLE = 4'b0001,
		WPN_STORE = 4'b0010,
		WPN_WAIT = 4'b0100,
		WPN_RESTORE = 4'b1000
	} wpn_state_t;

	wpn_state_t state;
	// working register set, one byte per command code
	logic [7:0] work [WPN_NREG];
	// walk index for bulk copies
	logic [7:0] idx;
	logic walk_last;
	// write permission under the lockout bits
	logic allowed;
	logic is_plain_write;
	// memory side
	logic nvm_wr;
	logic [7:0] nvm_waddr;
	logic [7:0] nvm_raddr;
	logic [7:0] nvm_rdata;
	logic nvm_start;
	logic nvm_busy;
	logic accept;

	// lowest set lock bit dominates nothing: each set bit only narrows the allowed set
	always_comb begin
		allowed = 1'b1;
		if (write_lockout_control[WPN_LOCK_ALL_BUT_ONOFF] && cmd_code != WPN_CMD_WRITE_LOCKOUT &&
			cmd_code != WPN_CMD_OPERATION && cmd_code != WPN_CMD_ON_OFF_CONFIG) begin
			allowed = 1'b0;
		end
		if (write_lockout_control[WPN_LOCK_ALL_BUT_OP] && cmd_code != WPN_CMD_WRITE_LOCKOUT &&
			cmd_code != WPN_CMD_OPERATION) begin
			allowed = 1'b0;
		end
		if (write_lockout_control[WPN_LOCK_ALL_BUT_WP] && cmd_code != WPN_CMD_WRITE_LOCKOUT) begin
			allowed = 1'b0;
		end
		// no other term exists, so a clear bit restricts nothing
	end

	// commands arriving while a bulk copy runs are ignored, not queued
	assign accept = cmd_valid && state == WPN_IDLE;
	assign is_plain_write = cmd_code != WPN_CMD_STORE_ALL && cmd_code != WPN_CMD_RESTORE_ALL &&
		cmd_code != WPN_CMD_STORE_ONE && cmd_code != WPN_CMD_RESTORE_ONE;
	assign walk_last = idx == 8'hff;

	// memory port steering: bulk walk or single code
	always_comb begin
		nvm_wr = 1'b0;
		nvm_waddr = idx;
		nvm_raddr = idx;
		nvm_start = 1'b0;
		if (state == WPN_STORE) begin
			nvm_wr = 1'b1;
			nvm_start = walk_last;
		end else if (accept && allowed && cmd_code == WPN_CMD_STORE_ONE && cmd_has_data) begin
			nvm_wr = 1'b1;
			nvm_waddr = cmd_data;
		end
		if (accept && cmd_code == WPN_CMD_RESTORE_ONE) begin
			nvm_raddr = cmd_data;
		end
	end

	wpn_nvm #(
		.STORE_CYC(STORE_CYC)
	) wpn_nvm_i (
		.clk(clk),
		.rst_n(rst_n),
		.wr_en(nvm_wr),
		.wr_addr(nvm_waddr),
		.wr_data(work[nvm_waddr]),
		.rd_addr(nvm_raddr),
		.rd_data(nvm_rdata),
		.hold_start(nvm_start),
		.hold_busy(nvm_busy)
	);

	// sequencer for bulk store and restore
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= WPN_IDLE;
			idx <= 8'h00;
		end else begin
			case (state)
				WPN_IDLE: begin
					idx <= 8'h00;
					if (accept && allowed && cmd_code == WPN_CMD_STORE_ALL) begin
						state <= WPN_STORE;
					end else if (accept && allowed && cmd_code == WPN_CMD_RESTORE_ALL) begin
						state <= WPN_RESTORE;
					end
				end
				WPN_STORE: begin
					idx <= idx + 8'h01;
					if (walk_last) begin
						state <= WPN_WAIT;
					end
				end
				WPN_WAIT: begin
					// hold off further commands for the programming time
					if (!nvm_busy && !nvm_start) begin
						state <= WPN_IDLE;
					end
				end
				WPN_RESTORE: begin
					idx <= idx + 8'h01;
					if (walk_last) begin
						state <= WPN_IDLE;
					end
				end
				default: begin
					state <= WPN_IDLE;
				end
			endcase
		end
	end

	// working set updates: plain writes, restore walk, restore of one code
	always_ff @(posedge clk) begin
		if (state == WPN_RESTORE) begin
			work[idx] <= nvm_rdata;
		end else if (accept && allowed && cmd_has_data && is_plain_write) begin
			work[cmd_code] <= cmd_data;
		end else if (accept && allowed && cmd_code == WPN_CMD_RESTORE_ONE && cmd_has_data) begin
			work[cmd_data] <= nvm_rdata;
		end
	end

	// lockout register; only the three lock bits are kept, the rest read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_lockout_control <= WPN_LOCK_RESET;
		end else if (accept && allowed && cmd_has_data && cmd_code == WPN_CMD_WRITE_LOCKOUT) begin
			// a host value with several lock bits keeps all of them; bits 4:0 are cleared
			write_lockout_control <= cmd_data & WPN_LOCK_MASK;
		end
	end

	// refused write reported as a one-cycle fault, register untouched
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			comm_fault <= 1'b0;
		end else begin
			comm_fault <= accept && !allowed;
		end
	end

	// busy while a bulk copy or the programming wait runs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd_busy <= 1'b0;
		end else begin
			cmd_busy <= (accept && allowed && (cmd_code == WPN_CMD_STORE_ALL || cmd_code == WPN_CMD_RESTORE_ALL)) ||
				(state == WPN_STORE) || (state == WPN_WAIT && (nvm_busy || nvm_start)) ||
				(state == WPN_RESTORE && !walk_last);
		end
	end

	// read-back of the working set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= (rd_code == WPN_CMD_WRITE_LOCKOUT) ? write_lockout_control : work[rd_code];
		end
	end

	// assertions
	chk_lock_wp_only: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && state == WPN_IDLE && write_lockout_control[WPN_LOCK_ALL_BUT_WP] &&
		cmd_code != WPN_CMD_WRITE_LOCKOUT
		|=> comm_fault) else $error("bit7 lock did not refuse write");
	chk_lock_op_pass: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && state == WPN_IDLE && write_lockout_control == 8'h40 && cmd_code == WPN_CMD_OPERATION
		|=> !comm_fault) else $error("bit6 lock refused operation");
	chk_lock_onoff: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && state == WPN_IDLE && write_lockout_control == 8'h20 &&
		cmd_code != WPN_CMD_WRITE_LOCKOUT && cmd_code != WPN_CMD_OPERATION && cmd_code != WPN_CMD_ON_OFF_CONFIG
		|=> comm_fault) else $error("bit5 lock did not refuse write");
	chk_unlocked_free: assert property (@(posedge clk) disable iff (!rst_n)
		cmd_valid && state == WPN_IDLE && write_lockout_control == 8'h00 |=> !comm_fault)
		else $error("unlocked write refused");
	chk_refused_keeps: assert property (@(posedge clk) disable iff (!rst_n)
		accept && !allowed |=> $stable(write_lockout_control)) else $error("refused write changed lockout");
	chk_store_start: assert property (@(posedge clk) disable iff (!rst_n)
		accept && allowed && cmd_code == WPN_CMD_STORE_ALL |=> state == WPN_STORE && cmd_busy)
		else $error("store-all did not start");
	chk_store_walk: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(state == WPN_STORE) |-> ##255 state == WPN_STORE ##1 state == WPN_WAIT)
		else $error("store walk length wrong");
	chk_restore_walk: assert property (@(posedge clk) disable iff (!rst_n)
		accept && allowed && cmd_code == WPN_CMD_RESTORE_ALL |=> state == WPN_RESTORE ##255 state == WPN_RESTORE ##1
		state == WPN_IDLE) else $error("restore walk length wrong");
	chk_store_one: assert property (@(posedge clk) disable iff (!rst_n)
		accept && allowed && cmd_code == WPN_CMD_STORE_ONE && cmd_has_data |-> nvm_wr && nvm_waddr == cmd_data)
		else $error("store-one wrote wrong entry");
	cov_store_all: cover property (@(posedge clk) disable iff (!rst_n) state == WPN_WAIT ##1 state == WPN_IDLE);
	cov_restore_all: cover property (@(posedge clk) disable iff (!rst_n) state == WPN_RESTORE && walk_last);
	cov_refused: cover property (@(posedge clk) disable iff (!rst_n) comm_fault);
	cov_restore_one: cover property (@(posedge clk) disable iff (!rst_n)
		accept && allowed && cmd_code == WPN_CMD_RESTORE_ONE && cmd_has_data);
endmodule

// file: wpn_host_model.sv
// host controller model that issues decoded bus writes to the command block
`timescale 1ns/10ps
module wpn_host_model
	import wpn_pkg::*;
(
	input wire logic clk,
	input wire logic cmd_busy,
	input wire logic comm_fault,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic cmd_has_data,
	output logic [7:0] cmd_data,
	output logic seen_fault,
	output logic seen_busy,
	output logic hang
);
	// all request lines start quiet
	initial begin
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		cmd_has_data = 1'b0;
		cmd_data = 8'h00;
		seen_fault = 1'b0;
		seen_busy = 1'b0;
		hang = 1'b0;
	end
	// waits out a running walk; long store times need a generous bound
	task automatic idle();
		int n;
		n = 0;
		while (cmd_busy !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 4000) hang = 1'b1;
	endtask
	// one whole write: code plus optional byte, then sample the answer
	task automatic send(input logic [7:0] c, input logic [7:0] d, input logic hd);
		idle();
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_data <= d;
		cmd_has_data <= hd;
		@(posedge clk);
		cmd_valid <= 1'b0;
		// released byte shows the inverse so a stale read cannot match
		cmd_data <= ~d;
		#1;
		seen_fault = comm_fault;
		seen_busy = cmd_busy;
	endtask
endmodule

// file: pmbus_write_protect_nvm_store_tb_top.sv
// self-checking bench for the lockout and non-volatile store block
`timescale 1ns/10ps
module pmbus_write_protect_nvm_store_tb_top
	import wpn_pkg::*;
;
	localparam int SIM_STORE = 20; // shortened programming time
	logic clk, rst_n, cmd_valid, cmd_has_data, cmd_busy, comm_fault, seen_fault, seen_busy, hang;
	logic [7:0] cmd_code, cmd_data, rd_code, rd_data, lock_q;
	logic [7:0] work [256]; // expected working set
	logic [7:0] nvm [256]; // expected stored copy
	logic [7:0] lock_m, d, lv;
	logic [31:0] seed;
	int fails, checks_done, cyc;
`define CHK(nm, ex, got) begin checks_done++; if ((ex) !== (got)) begin fails++; \
$display("BAD %s exp %h got %h", nm, ex, got); end end
	wpn_pmbus_cmd #(.STORE_CYC(SIM_STORE)) wpn_pmbus_cmd_i (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
		.cmd_code(cmd_code), .cmd_has_data(cmd_has_data), .cmd_data(cmd_data), .rd_code(rd_code),
		.rd_data(rd_data), .write_lockout_control(lock_q), .cmd_busy(cmd_busy), .comm_fault(comm_fault));
	wpn_host_model wpn_host_model_i (.clk(clk), .cmd_busy(cmd_busy), .comm_fault(comm_fault),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_has_data(cmd_has_data), .cmd_data(cmd_data),
		.seen_fault(seen_fault), .seen_busy(seen_busy), .hang(hang));
	// xorshift source, fixed start
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// which codes pass under the current lock bits
	function automatic logic allow(input logic [7:0] c, input logic [7:0] l);
		if (l[WPN_LOCK_ALL_BUT_WP]) return c == WPN_CMD_WRITE_LOCKOUT;
		if (l[WPN_LOCK_ALL_BUT_OP]) return c == WPN_CMD_WRITE_LOCKOUT || c == WPN_CMD_OPERATION;
		if (l[WPN_LOCK_ALL_BUT_ONOFF]) return c inside {WPN_CMD_WRITE_LOCKOUT, WPN_CMD_OPERATION, WPN_CMD_ON_OFF_CONFIG};
		return 1'b1;
	endfunction
	// clock, 25 ns period
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard, well above the expected run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000 || hang === 1'b1) begin
			fails++;
			close_out();
		end
	end
	// read one working-set byte back after the block goes idle
	task automatic peek(input logic [7:0] c, input logic [7:0] ex);
		wpn_host_model_i.idle();
		@(posedge clk);
		rd_code <= c;
		@(posedge clk);
		#1;
		`CHK("rd_data", ex, rd_data)
	endtask
	// one write through the host plus the model's view of it
	task automatic wr(input logic [7:0] c, input logic [7:0] v);
		wpn_host_model_i.send(c, v, 1'b1);
		`CHK("comm_fault", !allow(c, lock_m), seen_fault)
		if (allow(c, lock_m) && c == WPN_CMD_WRITE_LOCKOUT) lock_m = v & WPN_LOCK_MASK;
		else if (allow(c, lock_m)) work[c] = v;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// main sequence
	initial begin
		rst_n = 1'b0;
		rd_code = 8'h00;
		seed = 32'd38;
		lock_m = WPN_LOCK_RESET;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK("lock reset", WPN_LOCK_RESET, lock_q)
		`CHK("busy reset", 1'b0, cmd_busy)
		// one lock bit at a time, operation, on/off and code 05 tried under each
		for (int i = 0; i < 4; i++) begin
			// lock values 00, 20, 40, 80 in turn: one bit at most
			lv = (i == 0) ? 8'h00 : 8'h10 << i;
			seed = xs(seed);
			wr(WPN_CMD_WRITE_LOCKOUT, lv | (seed[7:0] & 8'h1f));
			`CHK("lock", lv, lock_q)
			for (int k = 0; k < 3; k++) begin
				seed = xs(seed);
				d = (k == 0) ? WPN_CMD_OPERATION : (k == 1) ? WPN_CMD_ON_OFF_CONFIG : 8'h05;
				wr(d, seed[15:8]);
				peek(d, work[d]);
			end
		end
		// mid-run reset with the tightest lock set: lockout must come back clear
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK("lock re-reset", WPN_LOCK_RESET, lock_q)
		`CHK("busy re-reset", 1'b0, cmd_busy)
		lock_m = WPN_LOCK_RESET;
		wr(WPN_CMD_WRITE_LOCKOUT, 8'h00);
		seed = xs(seed);
		wr(8'h06, seed[7:0]);
		wpn_host_model_i.send(WPN_CMD_STORE_ALL, 8'h00, 1'b0);
		`CHK("store busy", 1'b1, seen_busy)
		nvm[5] = work[5];
		nvm[6] = work[6];
		wr(8'h05, seed[15:8]);
		wr(8'h06, seed[23:16]);
		wpn_host_model_i.send(WPN_CMD_STORE_ONE, 8'h05, 1'b1);
		nvm[5] = work[5];
		wpn_host_model_i.send(WPN_CMD_RESTORE_ALL, 8'h00, 1'b0);
		`CHK("restore busy", 1'b1, seen_busy)
		// model working set now mirrors the stored copy
		work[5] = nvm[5];
		work[6] = nvm[6];
		peek(8'h05, nvm[5]);
		peek(8'h06, nvm[6]);
		wr(8'h05, seed[31:24]);
		wr(8'h06, ~seed[7:0]);
		wpn_host_model_i.send(WPN_CMD_RESTORE_ONE, 8'h06, 1'b1);
		work[6] = nvm[6];
		peek(8'h06, nvm[6]);
		peek(8'h05, work[5]);
		close_out();
	end
endmodule
